// File: verilog/atc_regs.vh
// Register offsets, field positions, reset values and decode constants.
`ifndef ATC_REGS_VH
`define ATC_REGS_VH
`define ATC_ADDR_SLOT_CTRL 8'h26
`define ATC_ADDR_OVF_STICKY 8'h2a
`define ATC_ADDR_OVF_LIVE 8'h2b
`define ATC_ADDR_AGC_STICKY 8'h2d
`define ATC_ADDR_RSV_LO 8'h27
`define ATC_ADDR_RSV_HI 8'h29
`define ATC_ADDR_RSV_44 8'h2c
`define ATC_SLOT_CTRL_RST 8'h02
`define ATC_SLOT_CTRL_WMASK 8'h1f
`define ATC_BIT_SWAP 4
`define ATC_BIT_EN_HI 3
`define ATC_BIT_EN_LO 2
`define ATC_BIT_EARLY_TRI 1
`define ATC_BIT_SLOT_MODE 0
`define ATC_BIT_OVF_LEFT 3
`define ATC_BIT_OVF_RIGHT 2
`define ATC_BIT_OVF_SHIFT 1
`define ATC_BIT_NOISE_LEFT 6
`define ATC_BIT_NOISE_RIGHT 5
`define ATC_BIT_DSP_STD 4
`define ATC_BIT_DSP_AUX 3
`define ATC_EN_BOTH 2'h0
`define ATC_EN_LEFT 2'h1
`define ATC_EN_RIGHT 2'h2
`define ATC_EN_NONE 2'h3
`endif

// File: verilog/atc_sticky.v
// Sticky flag bank: set by events, cleared by a read, set wins.
module atc_sticky #(
  parameter WIDTH = 5
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_event,
  input wire i_clear,
  output reg [WIDTH-1:0] o_flags
);
  wire [WIDTH-1:0] flags_next;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_flag
      // Set wins over the read clear so an event in the read cycle is kept.
      assign flags_next[g] = i_event[g] | (o_flags[g] & ~i_clear);
    end
  endgenerate

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_flags <= {WIDTH{1'b0}};
    end else begin
      o_flags <= flags_next;
    end
  end
endmodule // atc_sticky

// File: verilog/atc_ctrl.v
// Serial slot control and overflow/AGC/DSP flag registers.
`include "atc_regs.vh"

module atc_ctrl (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_rd,
  input wire [7:0] i_first_slot_offset,
  input wire [7:0] i_second_slot_offset,
  input wire [15:0] i_left_data,
  input wire [15:0] i_right_data,
  input wire i_ovf_left,
  input wire i_ovf_right,
  input wire i_ovf_shift,
  input wire i_noise_left,
  input wire i_noise_right,
  input wire i_dsp_std_int,
  input wire i_dsp_aux_int,
  output reg [7:0] o_reg_rdata,
  output reg [15:0] o_ch1_data,
  output reg [15:0] o_ch2_data,
  output reg o_ch1_en,
  output reg o_ch2_en,
  output reg o_early_tristate,
  output reg [7:0] o_ch1_offset,
  output reg [7:0] o_ch2_offset,
  output reg o_ch2_offset_from_ch1_end
);
  reg [4:0] ctrl_reg;
  reg [2:0] live_reg;
  wire rd_ovf;
  wire rd_agc;
  wire wr_ctrl;
  wire [2:0] ovf_flags;
  wire [3:0] agc_flags;
  wire [2:0] ovf_events;
  wire [3:0] agc_events;
  wire swap;
  wire [1:0] en_code;
  wire slot_mode;
  wire [7:0] ctrl_rst_val;
  wire [7:0] wdata_masked;
  reg [7:0] rdata_next;

  // True when a strobe targets the given register offset.
  function addr_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = strobe && (addr == target);
    end
  endfunction

  // True when the enable code lets out the channel with the given sole code.
  function chan_enabled;
    input [1:0] code;
    input [1:0] sole;
    begin
      chan_enabled = (code == `ATC_EN_BOTH) || (code == sole);
    end
  endfunction

  // Places the three overflow bits at their register positions.
  function [7:0] ovf_layout;
    input [2:0] bits;
    begin
      ovf_layout = 8'h00;
      ovf_layout[`ATC_BIT_OVF_LEFT] = bits[2];
      ovf_layout[`ATC_BIT_OVF_RIGHT] = bits[1];
      ovf_layout[`ATC_BIT_OVF_SHIFT] = bits[0];
    end
  endfunction

  assign rd_ovf = addr_hit(i_reg_rd, i_reg_addr, `ATC_ADDR_OVF_STICKY);
  assign rd_agc = addr_hit(i_reg_rd, i_reg_addr, `ATC_ADDR_AGC_STICKY);
  assign wr_ctrl = addr_hit(i_reg_wr, i_reg_addr, `ATC_ADDR_SLOT_CTRL);
  assign ovf_events = {i_ovf_left, i_ovf_right, i_ovf_shift};
  assign agc_events = {i_noise_left, i_noise_right,
                       i_dsp_std_int, i_dsp_aux_int};
  assign ctrl_rst_val = `ATC_SLOT_CTRL_RST;
  assign wdata_masked = i_reg_wdata & `ATC_SLOT_CTRL_WMASK;
  assign swap = ctrl_reg[`ATC_BIT_SWAP];
  assign en_code = ctrl_reg[`ATC_BIT_EN_HI:`ATC_BIT_EN_LO];
  assign slot_mode = ctrl_reg[`ATC_BIT_SLOT_MODE];

  // Only the control register is writable; reserved addresses are ignored.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_reg <= ctrl_rst_val[4:0];
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata_masked[4:0];
    end
  end

  // Overflow flags: bit 2 left, bit 1 right, bit 0 shifter.
  atc_sticky #(.WIDTH(3)) u_ovf (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_event(ovf_events),
    .i_clear(rd_ovf),
    .o_flags(ovf_flags)
  );

  // AGC and DSP flags: noise left, noise right, std, aux.
  atc_sticky #(.WIDTH(4)) u_agc (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_event(agc_events),
    .i_clear(rd_agc),
    .o_flags(agc_flags)
  );

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      live_reg <= 3'h0;
    end else begin
      live_reg <= ovf_events;
    end
  end

  always @* begin
    rdata_next = 8'h00;
    case (i_reg_addr)
      `ATC_ADDR_SLOT_CTRL: begin
        rdata_next = {3'h0, ctrl_reg};
      end
      `ATC_ADDR_OVF_STICKY: begin
        rdata_next = ovf_layout(ovf_flags);
      end
      `ATC_ADDR_OVF_LIVE: begin
        rdata_next = ovf_layout(live_reg);
      end
      `ATC_ADDR_AGC_STICKY: begin
        rdata_next[`ATC_BIT_NOISE_LEFT] = agc_flags[3];
        rdata_next[`ATC_BIT_NOISE_RIGHT] = agc_flags[2];
        rdata_next[`ATC_BIT_DSP_STD] = agc_flags[1];
        rdata_next[`ATC_BIT_DSP_AUX] = agc_flags[0];
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // Channel data after the optional swap.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ch1_data <= 16'h0000;
      o_ch2_data <= 16'h0000;
    end else if (swap) begin
      o_ch1_data <= i_right_data;
      o_ch2_data <= i_left_data;
    end else begin
      o_ch1_data <= i_left_data;
      o_ch2_data <= i_right_data;
    end
  end

  // Channel send enables from the two-bit code.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ch1_en <= 1'b0;
      o_ch2_en <= 1'b0;
    end else begin
      o_ch1_en <= chan_enabled(en_code, `ATC_EN_LEFT);
      o_ch2_en <= chan_enabled(en_code, `ATC_EN_RIGHT);
    end
  end

  // Early tristate option follows its control bit.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_early_tristate <= 1'b1;
    end else begin
      o_early_tristate <= ctrl_reg[`ATC_BIT_EARLY_TRI];
    end
  end

  // Slot offsets: channel two takes the second offset only in slot mode.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ch1_offset <= 8'h00;
      o_ch2_offset <= 8'h00;
      o_ch2_offset_from_ch1_end <= 1'b0;
    end else if (slot_mode) begin
      o_ch1_offset <= i_first_slot_offset;
      o_ch2_offset <= i_second_slot_offset;
      o_ch2_offset_from_ch1_end <= 1'b1;
    end else begin
      o_ch1_offset <= i_first_slot_offset;
      o_ch2_offset <= i_first_slot_offset;
      o_ch2_offset_from_ch1_end <= 1'b0;
    end
  end
endmodule // atc_ctrl

// File: test/atc_host.sv
// Host model issuing register strobes.
module atc_host (
  input wire i_ref_clk,
  input wire [7:0] i_rdata,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0
);
  timeunit 1ns / 1ps;
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    ok = (a < 8'h27 || a > 8'h29) && a != 8'h2c;
    @(posedge i_ref_clk)
      {o_addr, o_wdata, o_wr} <= {a, d & 8'h1f, ok};
    @(posedge i_ref_clk) {o_addr, o_wdata, o_wr} <= {~a, ~d, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_ref_clk) {o_addr, o_rd} <= {a, 1'b1};
    @(posedge i_ref_clk) {o_addr, o_rd} <= {~a, 1'b0};
    @(negedge i_ref_clk) q = i_rdata;
  endtask
endmodule // atc_host

// File: test/atc_ctrl_checker.sv
// Checker of control steering and flag reads.
module atc_chk (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] i_first_slot_offset,
  input wire [7:0] i_second_slot_offset,
  input wire [7:0] o_reg_rdata,
  input wire [7:0] o_ch1_offset,
  input wire [7:0] o_ch2_offset,
  input wire [15:0] i_left_data,
  input wire [15:0] i_right_data,
  input wire [15:0] o_ch1_data,
  input wire [15:0] o_ch2_data,
  input wire i_ovf_left,
  input wire i_ovf_right,
  input wire i_ovf_shift,
  input wire o_ch1_en,
  input wire o_ch2_en,
  input wire o_early_tristate,
  input wire o_ch2_offset_from_ch1_end
);
  timeunit 1ns / 1ps;
  reg [4:0] c_reg;
  reg [2:0] k_reg;
  reg r_reg;
  wire [2:0] ev = {i_ovf_left, i_ovf_right, i_ovf_shift};
  wire rd_a = i_reg_rd && i_reg_addr == 8'h2a;
  always @(posedge i_ref_clk) begin
    r_reg <= i_rst;
    if (i_rst) c_reg <= 5'h02;
    else if (i_reg_wr && i_reg_addr == 8'h26) c_reg <= i_reg_wdata[4:0];
    if (i_rst) k_reg <= 3'h0;
    else k_reg <= ev | (k_reg & ~{3{rd_a}});
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || r_reg);
  property p_sw;
    o_ch1_data == $past(c_reg[4] ? i_right_data : i_left_data); endproperty
  a_sw: assert property (p_sw) else $error("swap");
  property p_sw2;
    o_ch2_data == $past(c_reg[4] ? i_left_data : i_right_data); endproperty
  a_sw2: assert property (p_sw2) else $error("swap two");
  property p_o1;
    o_ch1_offset == $past(i_first_slot_offset); endproperty
  a_o1: assert property (p_o1) else $error("first offset");
  property p_en;
    {o_ch1_en, o_ch2_en} == ~$past(c_reg[3:2]); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_tm;
    {o_early_tristate, o_ch2_offset_from_ch1_end} == $past(c_reg[1:0]);
  endproperty
  a_tm: assert property (p_tm) else $error("mode");
  property p_of;
    o_ch2_offset ==
      $past(c_reg[0] ? i_second_slot_offset : i_first_slot_offset);
  endproperty
  a_of: assert property (p_of) else $error("offset");
  property p_rc;
    i_reg_rd && i_reg_addr == 8'h26 |=> o_reg_rdata == {3'h0, $past(c_reg)};
  endproperty
  a_rc: assert property (p_rc) else $error("control read");
  property p_hd;
    !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  a_hd: assert property (p_hd) else $error("read hold");
  property p_lv;
    i_reg_rd && i_reg_addr == 8'h2b |=>
      o_reg_rdata == {4'h0, $past(ev, 2), 1'b0}; endproperty
  a_lv: assert property (p_lv) else $error("live");
  property p_sk;
    rd_a |=> o_reg_rdata == {4'h0, $past(k_reg), 1'b0}; endproperty
  a_sk: assert property (p_sk) else $error("flag");
endmodule // atc_chk
bind atc_ctrl atc_chk chk (.*);

// File: test/adc_tdm_ctrl_overflow_flags_test.sv
// Testbench of the slot control and flag registers.
module adc_tdm_ctrl_overflow_flags_test;
  timeunit 1ns / 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] ev = 7'h00;
  logic [7:0] v;
  wire [7:0] ad, wd, q, o1, o2;
  wire w, r, e1, e2, et, om;
  wire [15:0] d1, d2;
  int fails = 0;
  int check_count = 0;
  logic [31:0] t [6] = '{{5'h00, 16'h1111, 3'b110, 8'h05},
    {5'h10, 16'h2222, 3'b110, 8'h05}, {5'h04, 16'h1111, 3'b100, 8'h05},
    {5'h08, 16'h1111, 3'b010, 8'h05}, {5'h0f, 16'h1111, 3'b001, 8'hff},
    {5'h13, 16'h2222, 3'b111, 8'hff}};
  logic [15:0] s [9] = '{16'h2b0e, 16'h2a0e, 16'h2a0e, 16'h2a0e,
    16'h2a00, 16'h2d78, 16'h2d00, 16'h2b00, 16'h2c00};
  always #4 clk = ~clk;
  atc_host h (.i_ref_clk(clk), .i_rdata(q), .o_addr(ad), .o_wdata(wd),
    .o_wr(w), .o_rd(r));
  atc_ctrl uut (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(ad),
    .i_reg_wr(w), .i_reg_wdata(wd), .i_reg_rd(r),
    .i_first_slot_offset(8'h05), .i_second_slot_offset(8'hff),
    .i_left_data(16'h1111), .i_right_data(16'h2222), .i_ovf_left(ev[2]),
    .i_ovf_right(ev[1]), .i_ovf_shift(ev[0]), .i_noise_left(ev[6]),
    .i_noise_right(ev[5]), .i_dsp_std_int(ev[4]), .i_dsp_aux_int(ev[3]),
    .o_reg_rdata(q), .o_ch1_data(d1), .o_ch2_data(d2), .o_ch1_en(e1),
    .o_ch2_en(e2), .o_early_tristate(et), .o_ch1_offset(o1),
    .o_ch2_offset(o2), .o_ch2_offset_from_ch1_end(om));
  task ck(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("BAD %0t %h %h", $time, g, x);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    h.rd(8'h26, v);
    ck(v, 8'h02);
    ck(et, 1'b1);
    $display("reset done");
    for (int i = 0; i < 6; i++) begin
      h.wr(8'h26, {3'h0, t[i][31:27]});
      h.rd(8'h26, v);
      ck(v, t[i][31:27]);
      ck({d1, e1, e2, et, o2}, t[i][26:0]);
      ck({d2, o1}, {(t[i][31] ? 16'h1111 : 16'h2222), 8'h05});
      ck(om, t[i][27]);
    end
    $display("control table done");
    @(posedge clk) ev <= 7'h7f;
    for (int i = 0; i < 9; i++) begin
      if (i == 3) @(posedge clk) ev <= 7'h00;
      h.rd(s[i][15:8], v);
      ck(v, s[i][7:0]);
    end
    $display("flag reads done");
    h.wr(8'h26, 8'h13);
    @(posedge clk) {rst, ev} <= 8'hff;
    repeat (3) @(posedge clk);
    {rst, ev} <= 8'h00;
    h.rd(8'h26, v);
    ck(v, 8'h02);
    ck({et, e1, e2, om}, 4'he);
    h.rd(8'h2a, v);
    ck(v, 8'h00);
    $display("second reset done");
    stop_test;
  end
  initial begin
    #20us;
    fails++;
    stop_test;
  end
endmodule // adc_tdm_ctrl_overflow_flags_test
